// [logic/temp_alert_defines.svh]
// Purpose: Offsets, field positions and reset values of the alert status word
// Assumes: Included by the alert block only; the package does not include it
// Notes: Definitions only
`ifndef TEMP_ALERT_DEFINES_SVH
`define TEMP_ALERT_DEFINES_SVH

`define ALARM_STATE_WORD_OFFSET 8'h02
`define ALARM_STATE_WORD_RESET 16'h0000
`define ALARM_BIT_CRC_FAIL 7
`define ALARM_BIT_SLEW_LIVE 6
`define ALARM_BIT_SLEW_STICKY 5
`define ALARM_BIT_HOT_LIVE 4
`define ALARM_BIT_COLD_LIVE 3
`define ALARM_BIT_HOT_CROSS 2
`define ALARM_BIT_COLD_CROSS 1
`define ALARM_BIT_DATA_READY 0
`define ALARM_READ_CLEAR_MASK 16'h00A7
`define ALARM_RESERVED_MASK 16'hFF00

`endif

// [logic/temp_alert_pkg.sv]
// Purpose: Types shared by the alert status block and its bench
// Assumes: Values are signed two's complement on a common 16-bit scale
// Notes: Constants live in temp_alert_defines.svh
package temp_alert_pkg;

  // One finished conversion
  typedef struct packed {
    logic signed [15:0] temp;
    logic signed [15:0] slew;
  } conv_result_type;

  // Programmed thresholds, same scale as the results
  typedef struct packed {
    logic signed [15:0] hotThreshold;
    logic signed [15:0] hotHysteresis;
    logic signed [15:0] coldThreshold;
    logic signed [15:0] coldHysteresis;
    logic signed [15:0] slewLimit;
  } alert_limits_type;

endpackage

// [logic/temp_alert_status_logic.sv]
// Purpose: Alert status word of a temperature sensor, with a serial-bus side on its own clock
// Assumes: Conversion results and limits are on core_clk; reads and checksum events on linkClk
// Notes: Status word and its read handshake cross between the two clocks by toggles
`include "temp_alert_defines.svh"

module temp_alert_status_logic
(
  // Core clock domain
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic coreEn,
  // Conversion side
  input wire logic convDone,
  input wire temp_alert_pkg::conv_result_type convResult,
  input wire temp_alert_pkg::alert_limits_type limits,
  output logic [15:0] statusWord,
  // Serial bus side, on the link clock
  input wire logic linkClk,
  input wire logic statusRead,
  output logic [15:0] readData,
  output logic readValid,
  output logic readBusy,
  input wire logic crcEnable,
  input wire logic busStop,
  input wire logic crcCheckFail,
  output logic writeDiscard
);

  logic [15:0] status_q;
  logic [15:0] hold_q;
  logic ackTog_q;
  logic [2:0] readSync_q;
  logic readSeen_q;
  logic [2:0] crcSync_q;
  logic crcSeen_q;
  logic readEvent;
  logic crcEvent;

  logic reqTog_q;
  logic crcTog_q;
  logic pending_q;
  logic crcArmed_q;
  logic [2:0] ackSync_q;
  logic ackSeen_q;
  logic ackEvent;
  logic [15:0] readData_q;
  logic readValid_q;
  logic writeDiscard_q;

  logic limitsValid;
  logic signed [16:0] tempX;
  logic signed [16:0] hotLow;
  logic signed [16:0] coldHigh;
  logic hotAbove;
  logic hotBelowHyst;
  logic coldBelow;
  logic coldAboveHyst;
  logic slewOver;
  logic [15:0] setMask;
  logic [15:0] liveNext;
  logic [15:0] status_d;

  // Link domain: read request and checksum event toggles

  always_ff @(posedge linkClk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reqTog_q <= 1'b0;
      pending_q <= 1'b0;
    end
    else if (statusRead && !pending_q)
    begin
      // A second read while one is in flight is dropped; readBusy shows it
      reqTog_q <= ~reqTog_q;
      pending_q <= 1'b1;
    end
    else if (ackEvent)
    begin
      pending_q <= 1'b0;
    end
  end

  // Enable is honoured only from the stop after it was set
  always_ff @(posedge linkClk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crcArmed_q <= 1'b0;
    end
    else if (busStop)
    begin
      crcArmed_q <= crcEnable;
    end
  end

  // Protected write that failed: tell the write path to drop it
  always_ff @(posedge linkClk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      writeDiscard_q <= 1'b0;
    end
    else
    begin
      writeDiscard_q <= crcCheckFail && crcArmed_q;
    end
  end

  // One toggle per failure; an even number of failures closer than the sync window can cancel out and set no flag
  always_ff @(posedge linkClk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crcTog_q <= 1'b0;
    end
    else if (crcCheckFail && crcArmed_q)
    begin
      crcTog_q <= ~crcTog_q;
    end
  end

  always_ff @(posedge linkClk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ackSync_q <= 3'h0;
      ackSeen_q <= 1'b0;
    end
    else
    begin
      ackSync_q <= {ackSync_q[1:0], ackTog_q};
      if (ackEvent)
      begin
        ackSeen_q <= ackSync_q[2];
      end
    end
  end

  assign ackEvent = (ackSync_q[1] == ackSync_q[2]) && (ackSync_q[2] != ackSeen_q);

  // Hold word was written in the same core cycle the ack toggled, so after three sync stages it is stable here
  always_ff @(posedge linkClk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readData_q <= 16'h0000;
      readValid_q <= 1'b0;
    end
    else
    begin
      readValid_q <= ackEvent;
      if (ackEvent)
      begin
        readData_q <= hold_q;
      end
    end
  end

  assign readData = readData_q;
  assign readValid = readValid_q;
  assign readBusy = pending_q;
  assign writeDiscard = writeDiscard_q;

  // Core domain: synchronisers, frozen with the rest while coreEn is low

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readSync_q <= 3'h0;
      readSeen_q <= 1'b0;
      crcSync_q <= 3'h0;
      crcSeen_q <= 1'b0;
    end
    else if (coreEn)
    begin
      readSync_q <= {readSync_q[1:0], reqTog_q};
      crcSync_q <= {crcSync_q[1:0], crcTog_q};
      if (readEvent)
      begin
        readSeen_q <= readSync_q[2];
      end
      if (crcEvent)
      begin
        crcSeen_q <= crcSync_q[2];
      end
    end
  end

  assign readEvent = (readSync_q[1] == readSync_q[2]) && (readSync_q[2] != readSeen_q);
  assign crcEvent = (crcSync_q[1] == crcSync_q[2]) && (crcSync_q[2] != crcSeen_q);

  // Threshold evaluation; 17 bits so limit minus hysteresis cannot wrap
  always_comb
  begin
    tempX = {convResult.temp[15], convResult.temp};
    hotLow = 17'({limits.hotThreshold[15], limits.hotThreshold} - {limits.hotHysteresis[15], limits.hotHysteresis});
    coldHigh = 17'({limits.coldThreshold[15], limits.coldThreshold}
      + {limits.coldHysteresis[15], limits.coldHysteresis});
    limitsValid = limits.hotThreshold > limits.coldThreshold;
    hotAbove = convResult.temp > limits.hotThreshold;
    hotBelowHyst = tempX < hotLow;
    coldBelow = convResult.temp < limits.coldThreshold;
    coldAboveHyst = tempX > coldHigh;
    slewOver = (convResult.slew > 16'sh0000) && (convResult.slew > limits.slewLimit);
  end

  always_comb
  begin
    liveNext = status_q & 16'(1 << `ALARM_BIT_HOT_LIVE | 1 << `ALARM_BIT_COLD_LIVE | 1 << `ALARM_BIT_SLEW_LIVE);
    setMask = 16'h0000;
    if (convDone)
    begin
      setMask[`ALARM_BIT_DATA_READY] = 1'b1;
      liveNext[`ALARM_BIT_SLEW_LIVE] = slewOver;
      setMask[`ALARM_BIT_SLEW_STICKY] = slewOver && !status_q[`ALARM_BIT_SLEW_LIVE];
      if (limitsValid)
      begin
        if (hotAbove)
        begin
          liveNext[`ALARM_BIT_HOT_LIVE] = 1'b1;
        end
        else if (hotBelowHyst)
        begin
          liveNext[`ALARM_BIT_HOT_LIVE] = 1'b0;
        end
        // Live bit doubles as the re-arm latch for the crossing flag
        setMask[`ALARM_BIT_HOT_CROSS] = (hotAbove && !status_q[`ALARM_BIT_HOT_LIVE])
          || (hotBelowHyst && status_q[`ALARM_BIT_HOT_LIVE]);
        if (coldBelow)
        begin
          liveNext[`ALARM_BIT_COLD_LIVE] = 1'b1;
        end
        else if (coldAboveHyst)
        begin
          liveNext[`ALARM_BIT_COLD_LIVE] = 1'b0;
        end
        setMask[`ALARM_BIT_COLD_CROSS] = (coldBelow && !status_q[`ALARM_BIT_COLD_LIVE])
          || (coldAboveHyst && status_q[`ALARM_BIT_COLD_LIVE]);
      end
    end
    setMask[`ALARM_BIT_CRC_FAIL] = crcEvent;
    status_d = status_q;
    if (readEvent)
    begin
      status_d = status_q & ~`ALARM_READ_CLEAR_MASK;
    end
    // Sets are applied last so an event in the read cycle survives
    status_d = (status_d & `ALARM_READ_CLEAR_MASK) | setMask | liveNext;
    status_d = status_d & ~`ALARM_RESERVED_MASK;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_q <= `ALARM_STATE_WORD_RESET;
    end
    else if (coreEn)
    begin
      status_q <= status_d;
    end
  end

  // Snapshot the word before clearing, then hand it back across
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hold_q <= `ALARM_STATE_WORD_RESET;
    end
    else if (coreEn && readEvent)
    begin
      hold_q <= status_q;
    end
  end

  // Toggles with the snapshot; the link side waits three stages, so the word has settled
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ackTog_q <= 1'b0;
    end
    else if (coreEn && readEvent)
    begin
      ackTog_q <= ~ackTog_q;
    end
  end

  assign statusWord = status_q;

endmodule // temp_alert_status_logic

// [verif/temp_alert_status_logic_sva.sv]
// Purpose: Port-level checks of the alert status word
// Assumes: Sees only the top module ports
// Notes: Link-side timing bounds assume coreEn high
module temp_alert_status_logic_sva
(
  // Core side
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic coreEn,
  input wire logic convDone,
  input wire temp_alert_pkg::conv_result_type convResult,
  input wire temp_alert_pkg::alert_limits_type limits,
  input wire logic [15:0] statusWord,
  // Link side
  input wire logic linkClk,
  input wire logic statusRead,
  input wire logic readValid,
  input wire logic readBusy,
  input wire logic crcEnable,
  input wire logic busStop,
  input wire logic crcCheckFail,
  input wire logic writeDiscard
);
  timeunit 1ns;
  timeprecision 1ps;
  resv_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    statusWord[15:8] == 8'h00) else $error("reserved bits set");
  ready_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    convDone && coreEn |=> statusWord[0]) else $error("ready flag missed");
  slew_live_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    convDone && coreEn |=> statusWord[6] == ($past(convResult.slew) > 0 &&
    $past(convResult.slew) > $past(limits.slewLimit))) else $error("slew live wrong");
  hot_live_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    convDone && coreEn && limits.hotThreshold > limits.coldThreshold && convResult.temp > limits.hotThreshold
    |=> statusWord[4]) else $error("hot live missed");
  cold_live_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    convDone && coreEn && limits.hotThreshold > limits.coldThreshold && convResult.temp < limits.coldThreshold
    |=> statusWord[3]) else $error("cold live missed");
  ready_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(statusWord[0]) |-> readBusy) else $error("ready cleared without read");
  slew_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    statusWord[5] && !readBusy |=> statusWord[5]) else $error("slew sticky lost");
  read_answer_a: assert property (@(posedge linkClk) disable iff (!rst_b)
    statusRead && !readBusy |=> readBusy[*3] ##[1:30] readValid) else $error("read not answered");
  crc_discard_a: assert property (@(posedge linkClk) disable iff (!rst_b)
    busStop && crcEnable ##1 crcCheckFail |=> writeDiscard) else $error("discard missed");
  cover property (@(posedge linkClk) writeDiscard);
  cover property (@(posedge core_clk) statusWord[2]);
  cover property (@(posedge core_clk) statusWord[3]);
endmodule // temp_alert_status_logic_sva

bind temp_alert_status_logic temp_alert_status_logic_sva chk (.core_clk(core_clk), .rst_b(rst_b), .coreEn(coreEn),
  .convDone(convDone), .convResult(convResult), .limits(limits), .statusWord(statusWord), .linkClk(linkClk),
  .statusRead(statusRead), .readValid(readValid), .readBusy(readBusy), .crcEnable(crcEnable),
  .busStop(busStop), .crcCheckFail(crcCheckFail), .writeDiscard(writeDiscard));

// [verif/serial_host_model.sv]
// Purpose: Host controller on the serial bus side
// Assumes: Drives on the falling link clock edge
// Notes: slow adds idle cycles before each request
module serial_host_model
(
  // Link side
  input wire logic linkClk,
  input wire logic readBusy,
  output logic statusRead,
  output logic busStop,
  output logic crcEnable,
  output logic crcCheckFail
);
  timeunit 1ns;
  timeprecision 1ps;
  int slow = 0;
  initial
  begin
    statusRead = 0;
    busStop = 0;
    crcEnable = 0;
    crcCheckFail = 0;
  end
  // Only one read may be in flight
  task automatic rd();
    repeat (slow) @(negedge linkClk);
    @(negedge linkClk);
    while (readBusy) @(negedge linkClk);
    statusRead = 1;
    @(negedge linkClk);
    statusRead = 0;
  endtask
  task automatic crc(input logic en);
    @(negedge linkClk);
    crcEnable = en;
    busStop = 1;
    @(negedge linkClk);
    busStop = 0;
    crcCheckFail = 1;
    @(negedge linkClk);
    crcCheckFail = 0;
  endtask
endmodule // serial_host_model

// [verif/tb_temp_alert_status_logic.sv]
// Purpose: Self-checking bench for the alert status word
// Assumes: Conversions driven on falling core_clk, host on linkClk
// Notes: Expected words queued by the driver, checked on readValid
module tb_temp_alert_status_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0;
  logic linkClk = 0;
  logic rst_b = 0;
  logic coreEn = 1;
  logic convDone = 0;
  temp_alert_pkg::conv_result_type convResult = '0;
  temp_alert_pkg::alert_limits_type limits = '0;
  logic [15:0] statusWord, readData;
  logic readValid, readBusy, statusRead, busStop, crcEnable, crcCheckFail, writeDiscard;
  logic [15:0] expQ[$];
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 core_clk = ~core_clk;
  // Offset start keeps the link clock out of phase
  initial #3.1 forever #6 linkClk = ~linkClk;
  temp_alert_status_logic DUT (.core_clk(core_clk), .rst_b(rst_b), .coreEn(coreEn), .convDone(convDone),
    .convResult(convResult), .limits(limits), .statusWord(statusWord), .linkClk(linkClk),
    .statusRead(statusRead), .readData(readData), .readValid(readValid), .readBusy(readBusy),
    .crcEnable(crcEnable), .busStop(busStop), .crcCheckFail(crcCheckFail), .writeDiscard(writeDiscard));
  serial_host_model host (.linkClk(linkClk), .readBusy(readBusy), .statusRead(statusRead),
    .busStop(busStop), .crcEnable(crcEnable), .crcCheckFail(crcCheckFail));
  task results();
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task conv(input logic [15:0] t, input logic [15:0] s);
    @(negedge core_clk);
    convResult = {t, s};
    convDone = 1;
    @(negedge core_clk);
    convDone = 0;
  endtask
  task rd(input logic [15:0] e);
    expQ.push_back(e);
    host.rd();
    while (expQ.size() != 0) @(negedge core_clk);
  endtask
  always @(negedge linkClk)
    if (readValid === 1'b1 && expQ.size() != 0)
    begin
      samples_checked++;
      if (readData !== expQ[0])
      begin
        fail_count++;
        $display("mismatch t=%0t got %h exp %h", $time, readData, expQ[0]);
      end
      void'(expQ.pop_front());
    end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    limits = {16'h03E8, 16'h0064, 16'hFC18, 16'h0064, 16'h0032};
    void'($urandom(32'h1C59));
    repeat (5) @(negedge core_clk);
    rst_b = 1;
    rd(16'h0000);
    conv(16'h03E9 + 16'($urandom % 200), 16'h0033);
    rd(16'h0075);
    rd(16'h0050);
    conv(16'h03B6, 16'h0033);
    rd(16'h0051);
    conv(16'h0383, 16'hFF00);
    rd(16'h0005);
    host.slow = 3;
    conv(16'hFC17 - 16'($urandom % 200), 16'h0000);
    rd(16'h000B);
    conv(16'hFC4A, 16'h0000);
    conv(16'hFC4A, 16'h0000);
    rd(16'h0009);
    conv(16'hFC7D, 16'h0000);
    rd(16'h0003);
    limits.hotThreshold = 16'hF000;
    conv(16'h7000, 16'h0000);
    rd(16'h0001);
    coreEn = 1'b0;
    conv(16'h0000, 16'h0040);
    coreEn = 1'b1;
    rd(16'h0000);
    host.crc(1'b1);
    chk({15'h0000, writeDiscard}, 16'h0001);
    repeat (10) @(negedge core_clk);
    rd(16'h0080);
    host.crc(1'b0);
    chk({15'h0000, writeDiscard}, 16'h0000);
    repeat (10) @(negedge core_clk);
    rd(16'h0000);
    results();
  end
endmodule // tb_temp_alert_status_logic
